/* File: hdl/usbfc_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 40 MHz clock, byte addresses on the register port
// Notes: Included by the design files of the function controller except the synchroniser
`ifndef USBFC_DEFINES_SVH
`define USBFC_DEFINES_SVH

`define USBFC_ADDR_W          24
`define USBFC_DATA_W          16
// Common register offsets
`define USBFC_OFS_DEV_ADDR    24'h060000
`define USBFC_OFS_PWR_CTRL    24'h060004
`define USBFC_OFS_IN_IRQ      24'h060008
`define USBFC_OFS_OUT_IRQ     24'h060010
`define USBFC_OFS_BUS_IRQ     24'h060018
`define USBFC_OFS_IN_MASK     24'h06001C
`define USBFC_OFS_OUT_MASK    24'h060024
`define USBFC_OFS_BUS_MASK    24'h06002C
`define USBFC_OFS_FRAME_LO    24'h060030
`define USBFC_OFS_FRAME_HI    24'h060034
`define USBFC_OFS_EP_SEL      24'h060038
// Indexed register offsets
`define USBFC_OFS_IN_PACKET_LIMIT     24'h060040
`define USBFC_OFS_IN_STAT     24'h060044
`define USBFC_OFS_IN_CFG      24'h060048
`define USBFC_OFS_OUT_PACKET_LIMIT    24'h06004C
`define USBFC_OFS_OUT_STAT    24'h060050
`define USBFC_OFS_OUT_CFG     24'h060054
`define USBFC_OFS_CNT_LO      24'h060058
`define USBFC_OFS_CNT_HI      24'h06005C
// Packet FIFO ports, one word apart
`define USBFC_OFS_FIFO0       24'h060080
`define USBFC_OFS_FIFO2       24'h060088
// Field positions
`define USBFC_ADDR_PEND_BIT   7
`define USBFC_PWR_ISO_BIT     7
`define USBFC_PWR_RST_BIT     3
`define USBFC_PWR_WAKE_BIT    2
`define USBFC_PWR_SUSP_BIT    1
`define USBFC_PWR_PERMIT_BIT  0
`define USBFC_BUS_RST_BIT     2
`define USBFC_BUS_RESUME_BIT  1
`define USBFC_BUS_SUSP_BIT    0
// Reset values
`define USBFC_EP_MASK_RST     8'h07
`define USBFC_BUS_MASK_RST    3'h4
`define USBFC_MAX_PACKET_SIZE_RST        8'h00
// Timing
`define USBFC_CLK_PERIOD_NS   25
`define USBFC_SE0_DETECT_NS   2600
`define USBFC_SE0_DETECT_CYC  ((`USBFC_SE0_DETECT_NS + `USBFC_CLK_PERIOD_NS - 1) / `USBFC_CLK_PERIOD_NS)
`define USBFC_RST_PULSE_NS    250
`define USBFC_RST_PULSE_CYC   ((`USBFC_RST_PULSE_NS + `USBFC_CLK_PERIOD_NS - 1) / `USBFC_CLK_PERIOD_NS)
`define USBFC_IDLE_MS         3
`define USBFC_IDLE_CYC        (`USBFC_IDLE_MS * 1000000 / `USBFC_CLK_PERIOD_NS)

`endif

/* File: hdl/usbfc_pkg.sv */
// Purpose: Shared types of the function controller
// Assumes: Widths from usbfc_defines.svh
// Notes: Structs carry grouped signals between the core and its neighbours
`include "usbfc_defines.svh"

package usbfc_pkg;
	typedef enum logic [1:0]
	{
		USBFC_ACTIVE    = 2'b00,
		USBFC_SUSPENDED = 2'b01,
		USBFC_BUSRESET  = 2'b10
	} usbfc_link_t;

	typedef struct packed
	{
		logic                       wr;
		logic                       rd;
		logic [`USBFC_ADDR_W-1:0]   addr;
		logic [`USBFC_DATA_W-1:0]   wdata;
	} usbfc_regbus_t;

	typedef struct packed
	{
		logic        sof;
		logic        frameOk;
		logic [10:0] frame;
		logic        inToken;
	} usbfc_token_t;

	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [1:0] ep;
		logic [7:0] data;
	} usbfc_fifo_req_t;
endpackage

/* File: hdl/usbfc_sync.sv */
// Purpose: Two-stage synchroniser for the bus line inputs
// Assumes: Inputs are asynchronous to clk
// Notes: First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none

module usbfc_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,   // System clock
	input  wire logic [W-1:0] async, // Raw inputs
	output logic      [W-1:0] sync   // Synchronised outputs
);
	logic [W-1:0] stage1;

	// Two flip-flops in series
	always_ff @(posedge clk)
	begin
		stage1 <= async;
		sync   <= stage1;
	end
endmodule

`default_nettype wire

/* File: hdl/usbfc_line_monitor.sv */
// Purpose: Watches the data lines for long SE0, idle and activity
// Assumes: Lines already synchronised to clk
// Notes: Idle tick repeats every IDLE_CYC cycles of an unchanged line
`timescale 1ns/1ps
`default_nettype none
`include "usbfc_defines.svh"

module usbfc_line_monitor #(
	parameter int IDLE_CYC = `USBFC_IDLE_CYC
) (
	input  wire logic clk,      // System clock
	input  wire logic rst,      // Synchronous reset
	input  wire logic dp,       // D+ level
	input  wire logic dm,       // D- level
	output logic      se0Long,  // SE0 held for detect time
	output logic      idleTick, // Pulse per idle period
	output logic      activity  // Pulse on any line change
);
	localparam int SE0_CYC = `USBFC_SE0_DETECT_CYC;
	localparam int CW = $clog2(IDLE_CYC + 1);

	logic [1:0]    lastLine;
	logic [7:0]    se0Cnt;
	logic [CW-1:0] idleCnt;
	logic          change;

	initial
	begin
		if (IDLE_CYC < 2) $error("IDLE_CYC too small");
	end

	assign change = {dp, dm} != lastLine;

	// Line history and change pulse
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			lastLine <= 2'h2;
			activity <= 1'b0;
		end
		else
		begin
			lastLine <= {dp, dm};
			activity <= change;
		end
	end

	// SE0 duration counter
	always_ff @(posedge clk)
	begin
		if (rst || dp || dm)
		begin
			se0Cnt  <= 8'h00;
			se0Long <= 1'b0;
		end
		else if (se0Cnt == 8'(SE0_CYC - 1))
			se0Long <= 1'b1;
		else
			se0Cnt <= se0Cnt + 8'h01;
	end

	// Inactivity counter, restarts after each tick
	always_ff @(posedge clk)
	begin
		if (rst || change)
		begin
			idleCnt  <= '0;
			idleTick <= 1'b0;
		end
		else if (idleCnt == CW'(IDLE_CYC - 1))
		begin
			idleCnt  <= '0;
			idleTick <= 1'b1;
		end
		else
		begin
			idleCnt  <= idleCnt + CW'(1);
			idleTick <= 1'b0;
		end
	end
endmodule

`default_nettype wire

/* File: hdl/usbfc_common_regs.sv */
// Purpose: Common registers and bus-state control of a full-speed function
// Assumes: Endpoint engine outside supplies events, tokens and FIFO data
// Notes: Per-endpoint CSR bits are plain storage here
// Notes on behaviour
// - Endpoint select register chooses which IN and OUT indexed registers show
// - Register defaults load on power-on reset, and on bus reset except status banks and bus mask; here bus reset clears bus mask bits 1:0
// - New address takes effect when control last-data flag falls
// - Software sets address pending; hardware clears it once address used
// - ISO with SOF wait holds packet until SOF; early IN gets empty packet
// - Reset seen after 2.6us SE0; core reset pulse low 250ns
// - While suspended and wakeup bit set, drive resume signaling
// - Suspended flag set on suspend; cleared by wakeup clear or resume read
// - Suspend is entered only when suspend permit is one
// - Writing one clears a status bit; zero leaves it
// - IN status bit per endpoint; OUT-only endpoint bits reserved
// - IN status survives bus reset; only power-on reset clears it
// - IN limit and IN status serve all endpoints; endpoint zero bidirectional
// - Without OUT endpoints OUT registers vanish, endpoint zero count stays
// - Per-endpoint limit, two CSRs, OUT counts; endpoint zero reduced
// - Bus event mask resets to 100b, only bus reset enabled
// - Bus status: bit2 reset, bit1 resume, bit0 suspend every 3ms idle
// - Masks gate only the interrupt pin; resume cannot be masked
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "usbfc_defines.svh"

module usbfc_common_regs #(
	parameter int       NUM_EP   = 8,               // Endpoints including zero
	parameter bit [7:0] IN_CAP   = 8'h07,           // Endpoints able to do IN
	parameter bit [7:0] OUT_ONLY = 8'h00,           // OUT-only endpoints
	parameter bit [7:0] EP_BIDIR = 8'h07,           // Direction-programmable endpoints
	parameter int       IDLE_CYC = `USBFC_IDLE_CYC  // Cycles of idle per suspend event
) (
	input  wire logic                        clk,          // System clock
	input  wire logic                        rst,          // Power-on reset
	input  wire usbfc_pkg::usbfc_regbus_t    bus,          // Register port request
	output logic     [`USBFC_DATA_W-1:0]     rdData,       // Read data, next cycle
	input  wire logic                        lineDp,       // D+ receiver, async
	input  wire logic                        lineDm,       // D- receiver, async
	output logic                             resumeDrive,  // Drive resume K state
	output logic                             coreResetN,   // core_reset_pulse_n
	output logic                             mcuIrqN,      // mcu_interrupt_n
	output logic     [6:0]                   activeAddr,   // Address in use
	input  wire logic                        ctrlLastData, // control_last_data
	input  wire usbfc_pkg::usbfc_token_t     token,        // Token events
	input  wire logic                        txLoaded,     // tx_packet_loaded
	input  wire logic                        isoEp,        // Selected IN endpoint is ISO
	output logic                             isoSendOk,    // Loaded packet may go
	output logic                             isoZeroLen,   // Answer IN with empty packet
	input  wire logic [7:0]                  inEvent,      // IN status set pulses
	input  wire logic [7:0]                  outEvent,     // OUT status set pulses
	output usbfc_pkg::usbfc_fifo_req_t       fifoReq,      // FIFO port strobes
	input  wire logic [7:0]                  fifoRdData,   // FIFO read byte
	output logic     [2:0]                   selEp         // Selected endpoint
);
	import usbfc_pkg::*;

	localparam bit HAS_OUT = (~IN_CAP & 8'hFE) != 8'h00 || OUT_ONLY != 8'h00;
	localparam bit [7:0] EP_MASK = 8'((1 << NUM_EP) - 1);
	localparam bit [7:0] IN_VALID = EP_MASK & ~OUT_ONLY;
	localparam bit [7:0] OUT_VALID = HAS_OUT ? (EP_MASK & ~EP_BIDIR & ~IN_CAP & 8'hFE) : 8'h00;
	localparam int RST_CYC = `USBFC_RST_PULSE_CYC;

	initial
	begin
		if (NUM_EP < 1 || NUM_EP > 8) $error("NUM_EP must be 1 to 8");
	end

	usbfc_link_t linkState;
	logic [1:0]  lineSync;
	logic        se0Long;
	logic        idleTick;
	logic        activity;
	logic        se0Prev;
	logic        busRstPulse;
	logic        anyRst;
	logic [7:0]  addrReg;
	logic        lastDataPrev;
	logic        isoWait;
	logic        wakeReq;
	logic        suspFlag;
	logic        suspPermit;
	logic [7:0]  inIrq;
	logic [7:0]  outIrq;
	logic [2:0]  busIrq;
	logic [7:0]  inMask;
	logic [7:0]  outMask;
	logic [2:0]  busMask;
	logic [10:0] frameNum;
	logic [7:0]  epSel;
	logic [3:0]  rstCnt;
	logic        sofSeen;
	logic        txPrev;
	logic [7:0]  inMaxp [NUM_EP];
	logic [11:0] inStat [NUM_EP];
	logic [3:0]  inCfg [NUM_EP];
	logic [7:0]  outMaxp [NUM_EP];
	logic [7:0]  outStat [NUM_EP];
	logic [1:0]  outCfg [NUM_EP];
	logic [5:0]  cntLo [NUM_EP];
	logic [11:0] cntHi [NUM_EP];
	logic        epOk;
	logic        outOk;
	logic [15:0] next_rdData;

	// Register hit for write or read
	function automatic logic hit(input logic [`USBFC_ADDR_W-1:0] a,
		input logic [`USBFC_ADDR_W-1:0] ofs);
		hit = a == ofs;
	endfunction

	function automatic logic wrHit(input logic [`USBFC_ADDR_W-1:0] ofs);
		wrHit = bus.wr && hit(bus.addr, ofs);
	endfunction

	// Line inputs and bus monitor
	usbfc_sync #(.W(2)) uSync
	(
		.clk   (clk),
		.async ({lineDp, lineDm}),
		.sync  (lineSync)
	);

	usbfc_line_monitor #(.IDLE_CYC(IDLE_CYC)) uMon
	(
		.clk      (clk),
		.rst      (rst),
		.dp       (lineSync[1]),
		.dm       (lineSync[0]),
		.se0Long  (se0Long),
		.idleTick (idleTick),
		.activity (activity)
	);

	assign busRstPulse = se0Long && !se0Prev;
	assign anyRst = rst || busRstPulse;
	assign selEp = epSel[2:0];
	assign epOk = epSel < 8'(NUM_EP);
	assign outOk = HAS_OUT && epOk && epSel != 8'h00;

	// Bus reset edge and core reset pulse
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			se0Prev <= 1'b0;
			rstCnt  <= 4'h0;
		end
		else
		begin
			se0Prev <= se0Long;
			if (busRstPulse)
				rstCnt <= 4'(RST_CYC);
			else if (rstCnt != 4'h0)
				rstCnt <= rstCnt - 4'h1;
		end
	end

	assign coreResetN = rstCnt == 4'h0;

	// Link state machine
	always_ff @(posedge clk)
	begin
		if (rst)
			linkState <= USBFC_ACTIVE;
		else
		begin
			case (linkState)
				USBFC_ACTIVE:
				begin
					if (se0Long)
						linkState <= USBFC_BUSRESET;
					else if (idleTick && suspPermit)
						linkState <= USBFC_SUSPENDED;
				end
				USBFC_SUSPENDED:
				begin
					if (activity || (wakeReq && resumeDrive))
						linkState <= USBFC_ACTIVE;
				end
				USBFC_BUSRESET:
				begin
					if (!se0Long)
						linkState <= USBFC_ACTIVE;
				end
				default: linkState <= USBFC_ACTIVE;
			endcase
		end
	end

	// Device address with deferred use
	always_ff @(posedge clk)
	begin
		if (anyRst)
		begin
			addrReg      <= 8'h00;
			activeAddr   <= 7'h00;
			lastDataPrev <= 1'b0;
		end
		else
		begin
			lastDataPrev <= ctrlLastData;
			if (wrHit(`USBFC_OFS_DEV_ADDR))
				addrReg <= bus.wdata[7:0];
			else if (lastDataPrev && !ctrlLastData && addrReg[`USBFC_ADDR_PEND_BIT])
				addrReg[`USBFC_ADDR_PEND_BIT] <= 1'b0;
			if (lastDataPrev && !ctrlLastData)
				activeAddr <= addrReg[6:0];
		end
	end

	// Suspend and resume control bits
	always_ff @(posedge clk)
	begin
		if (anyRst)
		begin
			isoWait    <= 1'b0;
			wakeReq    <= 1'b0;
			suspPermit <= 1'b0;
			suspFlag   <= 1'b0;
		end
		else
		begin
			if (wrHit(`USBFC_OFS_PWR_CTRL))
			begin
				isoWait    <= bus.wdata[`USBFC_PWR_ISO_BIT];
				wakeReq    <= bus.wdata[`USBFC_PWR_WAKE_BIT];
				suspPermit <= bus.wdata[`USBFC_PWR_PERMIT_BIT];
			end
			if (linkState == USBFC_ACTIVE && idleTick && suspPermit)
				suspFlag <= 1'b1;
			else if (wrHit(`USBFC_OFS_PWR_CTRL) && wakeReq && !bus.wdata[`USBFC_PWR_WAKE_BIT])
				suspFlag <= 1'b0;
			else if (bus.rd && hit(bus.addr, `USBFC_OFS_BUS_IRQ) && busIrq[`USBFC_BUS_RESUME_BIT])
				suspFlag <= 1'b0;
		end
	end

	// Resume signaling output
	always_ff @(posedge clk)
	begin
		if (anyRst)
			resumeDrive <= 1'b0;
		else
			resumeDrive <= suspFlag && wakeReq;
	end

	// Status banks, set wins over clear, kept across bus reset
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			inIrq  <= 8'h00;
			outIrq <= 8'h00;
			busIrq <= 3'h0;
		end
		else
		begin
			inIrq <= ((wrHit(`USBFC_OFS_IN_IRQ) ? inIrq & ~bus.wdata[7:0] : inIrq)
				| inEvent) & IN_VALID;
			outIrq <= ((wrHit(`USBFC_OFS_OUT_IRQ) ? outIrq & ~bus.wdata[7:0] : outIrq)
				| outEvent) & OUT_VALID;
			busIrq <= (wrHit(`USBFC_OFS_BUS_IRQ) ? busIrq & ~bus.wdata[2:0] : busIrq)
				| {busRstPulse, linkState == USBFC_SUSPENDED && activity, idleTick};
		end
	end

	// Interrupt masks
	always_ff @(posedge clk)
	begin
		if (rst)
			busMask <= `USBFC_BUS_MASK_RST;
		else if (wrHit(`USBFC_OFS_BUS_MASK))
			busMask <= bus.wdata[2:0];
		else if (busRstPulse)
			busMask[1:0] <= 2'h0;
		if (anyRst)
		begin
			inMask  <= `USBFC_EP_MASK_RST & IN_VALID;
			outMask <= `USBFC_EP_MASK_RST & OUT_VALID;
		end
		else
		begin
			if (wrHit(`USBFC_OFS_IN_MASK))
				inMask <= bus.wdata[7:0];
			if (wrHit(`USBFC_OFS_OUT_MASK) && HAS_OUT)
				outMask <= bus.wdata[7:0];
		end
	end

	// Interrupt pin, resume not maskable
	always_ff @(posedge clk)
	begin
		if (rst)
			mcuIrqN <= 1'b1;
		else
			mcuIrqN <= !(|(inIrq & inMask) || |(outIrq & outMask)
				|| |(busIrq & busMask & 3'h5) || busIrq[`USBFC_BUS_RESUME_BIT]);
	end

	// Frame number and endpoint select
	always_ff @(posedge clk)
	begin
		if (anyRst)
		begin
			frameNum <= 11'h000;
			epSel    <= 8'h00;
		end
		else
		begin
			if (token.sof && token.frameOk)
				frameNum <= token.frame;
			else if (wrHit(`USBFC_OFS_FRAME_LO))
				frameNum[7:0] <= bus.wdata[7:0];
			else if (wrHit(`USBFC_OFS_FRAME_HI))
				frameNum[10:8] <= bus.wdata[2:0];
			if (wrHit(`USBFC_OFS_EP_SEL))
				epSel <= bus.wdata[7:0];
		end
	end

	// ISO start-of-frame wait
	always_ff @(posedge clk)
	begin
		if (anyRst)
		begin
			sofSeen <= 1'b0;
			txPrev  <= 1'b0;
		end
		else
		begin
			txPrev <= txLoaded;
			if (txLoaded && !txPrev)
				sofSeen <= 1'b0;
			else if (token.sof)
				sofSeen <= 1'b1;
		end
	end

	assign isoSendOk = txLoaded && (!isoWait || !isoEp || sofSeen);
	assign isoZeroLen = token.inToken && isoWait && isoEp && txLoaded && !sofSeen;

	// Indexed endpoint storage
	always_ff @(posedge clk)
	begin
		if (anyRst)
		begin
			for (int i = 0; i < NUM_EP; i++)
			begin
				inMaxp[i]  <= `USBFC_MAX_PACKET_SIZE_RST;
				inStat[i]  <= 12'h000;
				inCfg[i]   <= 4'h0;
				outMaxp[i] <= `USBFC_MAX_PACKET_SIZE_RST;
				outStat[i] <= 8'h00;
				outCfg[i]  <= 2'h0;
				cntLo[i]   <= 6'h00;
				cntHi[i]   <= 12'h000;
			end
		end
		else if (epOk)
		begin
			if (wrHit(`USBFC_OFS_IN_PACKET_LIMIT))
				inMaxp[selEp] <= bus.wdata[7:0];
			if (wrHit(`USBFC_OFS_IN_STAT))
				inStat[selEp] <= bus.wdata[11:0];
			if (wrHit(`USBFC_OFS_IN_CFG) && selEp != 3'h0)
				inCfg[selEp] <= bus.wdata[3:0];
			if (outOk && wrHit(`USBFC_OFS_OUT_PACKET_LIMIT))
				outMaxp[selEp] <= bus.wdata[7:0];
			if (outOk && wrHit(`USBFC_OFS_OUT_STAT))
				outStat[selEp] <= bus.wdata[7:0];
			if (outOk && wrHit(`USBFC_OFS_OUT_CFG))
				outCfg[selEp] <= bus.wdata[1:0];
			if ((HAS_OUT || selEp == 3'h0) && wrHit(`USBFC_OFS_CNT_LO))
				cntLo[selEp] <= bus.wdata[5:0];
			if ((HAS_OUT || selEp == 3'h0) && wrHit(`USBFC_OFS_CNT_HI))
				cntHi[selEp] <= bus.wdata[11:0];
		end
	end

	// FIFO port strobes
	assign fifoReq.wr = bus.wr && bus.addr >= `USBFC_OFS_FIFO0 && bus.addr <= `USBFC_OFS_FIFO2
		&& bus.addr[1:0] == 2'h0;
	assign fifoReq.rd = bus.rd && bus.addr >= `USBFC_OFS_FIFO0 && bus.addr <= `USBFC_OFS_FIFO2
		&& bus.addr[1:0] == 2'h0;
	assign fifoReq.ep = bus.addr[3:2];
	assign fifoReq.data = bus.wdata[7:0];

	// Read decode, unmapped reads zero
	always_comb
	begin
		next_rdData = 16'h0000;
		case (bus.addr)
			`USBFC_OFS_DEV_ADDR: next_rdData = {8'h00, addrReg};
			`USBFC_OFS_PWR_CTRL: next_rdData = {8'h00, isoWait, 3'h0, se0Long, wakeReq,
				suspFlag, suspPermit};
			`USBFC_OFS_IN_IRQ:   next_rdData = {8'h00, inIrq};
			`USBFC_OFS_OUT_IRQ:  next_rdData = {8'h00, outIrq};
			`USBFC_OFS_BUS_IRQ:  next_rdData = {13'h0000, busIrq};
			`USBFC_OFS_IN_MASK:  next_rdData = {8'h00, inMask};
			`USBFC_OFS_OUT_MASK: next_rdData = {8'h00, outMask};
			`USBFC_OFS_BUS_MASK: next_rdData = {13'h0000, busMask};
			`USBFC_OFS_FRAME_LO: next_rdData = {8'h00, frameNum[7:0]};
			`USBFC_OFS_FRAME_HI: next_rdData = {13'h0000, frameNum[10:8]};
			`USBFC_OFS_EP_SEL:   next_rdData = {8'h00, epSel};
			`USBFC_OFS_IN_PACKET_LIMIT:  next_rdData = epOk ? {8'h00, inMaxp[selEp]} : 16'h0000;
			`USBFC_OFS_IN_STAT:  next_rdData = epOk ? {4'h0, inStat[selEp]} : 16'h0000;
			`USBFC_OFS_IN_CFG:   next_rdData = epOk ? {12'h000, inCfg[selEp]} : 16'h0000;
			`USBFC_OFS_OUT_PACKET_LIMIT: next_rdData = outOk ? {8'h00, outMaxp[selEp]} : 16'h0000;
			`USBFC_OFS_OUT_STAT: next_rdData = outOk ? {8'h00, outStat[selEp]} : 16'h0000;
			`USBFC_OFS_OUT_CFG:  next_rdData = outOk ? {14'h0000, outCfg[selEp]} : 16'h0000;
			`USBFC_OFS_CNT_LO:   next_rdData = epOk ? {10'h000, cntLo[selEp]} : 16'h0000;
			`USBFC_OFS_CNT_HI:   next_rdData = epOk ? {4'h0, cntHi[selEp]} : 16'h0000;
			default:             next_rdData = fifoReq.rd ? {8'h00, fifoRdData} : 16'h0000;
		endcase
	end

	// Read data register
	always_ff @(posedge clk)
	begin
		if (rst || !bus.rd)
			rdData <= 16'h0000;
		else
			rdData <= next_rdData;
	end
endmodule

`default_nettype wire

/* File: tb/usbfc_regs_checker.sv */
// Purpose: Port assertions for the common register block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every usbfc_common_regs instance
`timescale 1ns/1ps
`default_nettype none
module usbfc_regs_checker (
	input wire logic                     clk,         // Clock
	input wire logic                     rst,         // Reset
	input wire usbfc_pkg::usbfc_regbus_t bus,         // Register request
	input wire logic [15:0]              rdData,      // Read data
	input wire logic                     lineDp,      // D+ line
	input wire logic                     lineDm,      // D- line
	input wire logic                     resumeDrive, // Resume drive
	input wire logic                     coreResetN,  // Core reset pulse
	input wire logic                     mcuIrqN,     // Interrupt
	input wire logic [6:0]               activeAddr,  // Address in use
	input wire usbfc_pkg::usbfc_token_t  token,       // Token events
	input wire logic                     isoSendOk,   // ISO send allowed
	input wire logic                     isoZeroLen,  // ISO empty packet
	input wire usbfc_pkg::usbfc_fifo_req_t fifoReq,   // FIFO strobes
	input wire logic [7:0]               fifoRdData   // FIFO byte
);
	import usbfc_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Read answer, reset state and bus reset pulse
	a_read_idle: assert property (!$past(bus.rd) |-> rdData == 16'h0000)
		else $error("read data outside read answer");
	a_reset_outs: assert property ($past(rst) |-> rdData == 16'h0000 && mcuIrqN
		&& coreResetN && !resumeDrive && activeAddr == 7'h00) else $error("bad reset state");
	a_pulse_len: assert property ($fell(coreResetN) |=> !coreResetN [*8] ##1 !coreResetN
		##1 coreResetN) else $error("core reset pulse length wrong");
	a_pulse_cause: assert property ($fell(coreResetN) |-> !$past(lineDp, 8)
		&& !$past(lineDm, 8) && !$past(lineDp, 90)) else $error("reset pulse without SE0");
	// FIFO strobes copy the bus cycle
	a_fifo_write: assert property (bus.wr && bus.addr == 24'h060088 |-> fifoReq.wr
		&& fifoReq.ep == 2'h2 && fifoReq.data == bus.wdata[7:0]) else $error("fifo write");
	a_fifo_read: assert property (bus.rd && bus.addr == 24'h060080 |=>
		rdData[7:0] == $past(fifoRdData)) else $error("fifo read data");
	a_fifo_quiet: assert property (!bus.wr && !bus.rd |-> !fifoReq.wr && !fifoReq.rd)
		else $error("fifo strobe without request");
	a_iso_empty: assert property (isoZeroLen |-> token.inToken && !isoSendOk)
		else $error("empty packet without IN token");
	// Main scenarios reached
	c_bus_reset: cover property ($fell(coreResetN));
	c_iso_empty: cover property (isoZeroLen);
	c_resume: cover property ($rose(resumeDrive));
endmodule
bind usbfc_common_regs usbfc_regs_checker u_chk (.clk, .rst, .bus, .rdData, .lineDp,
	.lineDm, .resumeDrive, .coreResetN, .mcuIrqN, .activeAddr, .token, .isoSendOk,
	.isoZeroLen, .fifoReq, .fifoRdData);
`default_nettype wire

/* File: tb/usbfc_host_model.sv */
// Purpose: Host side of the full-speed data lines
// Assumes: Mode chosen by the bench
// Notes: Idle J, SE0 for bus reset, J/K toggling as traffic
`timescale 1ns/1ps
`default_nettype none
module usbfc_host_model (
	input  wire logic       clk,  // Pacing clock
	input  wire logic [1:0] mode, // 0 idle, 1 reset, 2 traffic
	output var logic        dp,   // D+ line
	output var logic        dm    // D- line
);
	initial {dp, dm} = 2'b10;
	// Line state per mode
	always @(posedge clk)
	begin
		case (mode)
			2'd0: {dp, dm} <= 2'b10;
			2'd1: {dp, dm} <= 2'b00;
			default: {dp, dm} <= {dm, dp};
		endcase
	end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the common register block
// Assumes: 40 MHz clock, short idle period
// Notes: IN status tracked by a small model
`timescale 1ns/1ps
`default_nettype none
module tb;
	import usbfc_pkg::*;
	logic            clk = 0;
	logic            rst = 1;
	usbfc_regbus_t   bus = '0;
	logic [15:0]     rdData, v;
	logic            lineDp, lineDm, resumeDrive, coreResetN, mcuIrqN;
	logic [6:0]      activeAddr;
	logic            ctrlLastData = 0, txLoaded = 0, isoEp = 0;
	usbfc_token_t    token = '0;
	logic            isoSendOk, isoZeroLen;
	logic [7:0]      inEvent = 0, outEvent = 0, fifoRdData = 0;
	usbfc_fifo_req_t fifoReq;
	logic [2:0]      selEp;
	logic [1:0]      mode = 0;
	logic [15:0]     rnd = 16'd26512;
	int              num_errors = 0, checked = 0, mIn = 0;
	logic [39:0]     rstTab [8] = '{{24'h060000, 16'h0}, {24'h060004, 16'h0},
		{24'h060008, 16'h0}, {24'h060018, 16'h0}, {24'h06001C, 16'h7},
		{24'h06002C, 16'h4}, {24'h060038, 16'h0}, {24'h060020, 16'h0}};
	always #12.5 clk = ~clk;
	usbfc_host_model host (.clk, .mode, .dp(lineDp), .dm(lineDm));
	usbfc_common_regs #(.NUM_EP(8), .IN_CAP(8'h7F), .OUT_ONLY(8'h80), .EP_BIDIR(8'h07),
		.IDLE_CYC(200)) dut (.clk, .rst, .bus, .rdData, .lineDp, .lineDm, .resumeDrive,
		.coreResetN, .mcuIrqN, .activeAddr, .ctrlLastData, .token, .txLoaded, .isoEp,
		.isoSendOk, .isoZeroLen, .inEvent, .outEvent, .fifoReq, .fifoRdData, .selEp);
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic chkReg(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkPin(input string n, input logic e, input logic g);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic wr(input logic [23:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [23:0] a);
		@(posedge clk);
		bus <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 v = rdData;
	endtask
	task automatic rdChk(input logic [23:0] a, input logic [15:0] e);
		rd(a);
		chkReg($sformatf("reg %h", a), e, v);
	endtask
	task automatic wait2;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog against a hang
	initial
	begin
		#(25 * 8000);
		num_errors++;
		stop_test();
	end
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		foreach (rstTab[i]) rdChk(rstTab[i][39:16], rstTab[i][15:0]);
		$display("reset values done");
		@(posedge clk) {inEvent, outEvent} <= 16'hFFFF;
		@(posedge clk) {inEvent, outEvent} <= 16'h0000;
		mIn = 8'hFF & ~8'h80;
		rdChk(24'h060008, mIn[15:0]);
		rdChk(24'h060010, 16'h0080);
		wait2();
		chkPin("mcuIrqN", 1'b0, mcuIrqN);
		wr(24'h060008, 16'h0000);
		rdChk(24'h060008, mIn[15:0]);
		rnd = lfsr(rnd);
		wr(24'h060008, rnd);
		mIn &= ~int'(rnd[7:0]);
		rdChk(24'h060008, mIn[15:0]);
		wr(24'h06001C, 16'h0000);
		wait2();
		chkPin("mcuIrqN", 1'b1, mcuIrqN);
		wr(24'h060008, 16'h00FF);
		mIn = 0;
		$display("status banks done");
		wr(24'h060000, 16'h00AA);
		rdChk(24'h060000, 16'h00AA);
		chkReg("activeAddr", 16'h0000, {9'h0, activeAddr});
		@(posedge clk) ctrlLastData <= 1'b1;
		wait2();
		ctrlLastData <= 1'b0;
		repeat (4) @(posedge clk);
		chkReg("activeAddr", 16'h002A, {9'h0, activeAddr});
		rdChk(24'h060000, 16'h002A);
		$display("address done");
		repeat (220) @(posedge clk);
		rd(24'h060018);
		chkReg("suspend event", 16'h0001, v & 16'h0001);
		rdChk(24'h060004, 16'h0000);
		chkPin("mcuIrqN", 1'b1, mcuIrqN);
		wr(24'h060004, 16'h0001);
		repeat (220) @(posedge clk);
		rdChk(24'h060004, 16'h0003);
		wr(24'h060004, 16'h0005);
		wait2();
		chkPin("resumeDrive", 1'b1, resumeDrive);
		wr(24'h060004, 16'h0000);
		wait2();
		chkPin("resumeDrive", 1'b0, resumeDrive);
		rdChk(24'h060004, 16'h0000);
		wr(24'h060004, 16'h0001);
		repeat (220) @(posedge clk);
		mode <= 2'd2;
		wait2();
		mode <= 2'd0;
		wait2();
		wait2();
		chkPin("mcuIrqN", 1'b0, mcuIrqN);
		rd(24'h060018);
		chkReg("resume event", 16'h0002, v & 16'h0002);
		rdChk(24'h060004, 16'h0001);
		wr(24'h060004, 16'h0000);
		wr(24'h060018, 16'h0007);
		$display("suspend done");
		wr(24'h060038, 16'h0002);
		#1 chkReg("selEp", 16'h0002, {13'h0, selEp});
		@(posedge clk) inEvent <= 8'h01;
		@(posedge clk) inEvent <= 8'h00;
		mIn = 1;
		mode <= 2'd1;
		repeat (130) @(posedge clk);
		rdChk(24'h060004, 16'h0008);
		mode <= 2'd0;
		repeat (10) @(posedge clk);
		rdChk(24'h060004, 16'h0000);
		rd(24'h060018);
		chkReg("bus reset event", 16'h0004, v & 16'h0004);
		chkPin("mcuIrqN", 1'b0, mcuIrqN);
		rdChk(24'h060008, mIn[15:0]);
		rdChk(24'h060000, 16'h0000);
		rdChk(24'h06001C, 16'h0007);
		chkReg("selEp", 16'h0000, {13'h0, selEp});
		wr(24'h060008, 16'h00FF);
		wr(24'h060018, 16'h0007);
		wait2();
		chkPin("mcuIrqN", 1'b1, mcuIrqN);
		$display("bus reset done");
		isoEp <= 1'b1;
		wr(24'h060004, 16'h0080);
		@(posedge clk) txLoaded <= 1'b1;
		wait2();
		chkPin("isoSendOk", 1'b0, isoSendOk);
		@(posedge clk) token.inToken <= 1'b1;
		#1 chkPin("isoZeroLen", 1'b1, isoZeroLen);
		@(posedge clk) token <= '{1'b1, 1'b0, 11'h000, 1'b0};
		@(posedge clk) token.sof <= 1'b0;
		#1 chkPin("isoSendOk", 1'b1, isoSendOk);
		$display("iso done");
		repeat (4)
		begin
			rnd = lfsr(rnd);
			fifoRdData <= rnd[7:0];
			rdChk(24'h060080, {8'h00, rnd[7:0]});
			wr(24'h060088, rnd);
		end
		$display("fifo done");
		stop_test();
	end
endmodule
`default_nettype wire
